// >>> inc/tfr_pkg.sv
package tfr_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] TFR_OFS_CNT_HI  = 8'h00;
  localparam logic [7:0] TFR_OFS_CNT_LO  = 8'h04;
  localparam logic [7:0] TFR_OFS_ALT_HI  = 8'h08;
  localparam logic [7:0] TFR_OFS_ALT_LO  = 8'h0C;
  localparam logic [7:0] TFR_OFS_STATUS  = 8'h10;
  localparam logic [7:0] TFR_OFS_CTRL1   = 8'h14;
  localparam logic [7:0] TFR_OFS_CTRL2   = 8'h18;

  // Field positions.
  localparam int TFR_BIT_OVF       = 7;
  localparam int TFR_BIT_OVF_IE    = 7;
  localparam int TFR_BIT_EDGE      = 2;
  localparam int TFR_CSEL_LSB      = 0;

  // Counter and control values.
  localparam logic [15:0] TFR_RELOAD     = 16'hFFFC;
  localparam logic [15:0] TFR_CNT_MAX    = 16'hFFFF;
  localparam logic [7:0]  TFR_CTRL_RST   = 8'h00;
  localparam logic [2:0]  TFR_MASK_DIV2  = 3'h1;
  localparam logic [2:0]  TFR_MASK_DIV4  = 3'h3;
  localparam logic [2:0]  TFR_MASK_DIV8  = 3'h7;

  // Clock source selection codes.
  typedef enum logic [1:0] {
    TFR_CLK_DIV4 = 2'h0,
    TFR_CLK_DIV2 = 2'h1,
    TFR_CLK_DIV8 = 2'h2,
    TFR_CLK_EXT  = 2'h3
  } tfr_csel_t;

  // AXI responses.
  localparam logic [1:0] TFR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TFR_RESP_SLVERR = 2'h2;

endpackage : tfr_pkg

// >>> design/tfr_edge_sync.sv
`timescale 1ns/1ps
module tfr_edge_sync
  import tfr_pkg::*;
(
  // Clock and reset.
  input  wire logic CLK_SYS,
  input  wire logic RSTN,
  // Pin and control.
  input  wire logic PIN,
  input  wire logic RISING,
  // One-cycle active edge pulse.
  output logic      EDGE
);

  logic sync1_reg, sync2_reg, hist_reg;

  // Two flops resynchronise the pin; a third holds the previous level for edge detection.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      hist_reg  <= 1'b1;
    end else begin
      sync1_reg <= PIN;
      sync2_reg <= sync1_reg;
      hist_reg  <= sync2_reg;
    end
  end

  // Exactly one pulse per selected transition, since the history flop follows at once.
  assign EDGE = RISING ? (sync2_reg & ~hist_reg) : (~sync2_reg & hist_reg);

endmodule : tfr_edge_sync

// >>> design/tfr_timer.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module tfr_timer
  import tfr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              CLK_SYS,
  input  wire logic              RSTN,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Core and pin signals.
  input  wire logic              CPU_IMASK,
  input  wire logic              WAIT_MODE,
  input  wire logic              HALT_MODE,
  input  wire logic              EXT_CLK_PIN,
  input  wire logic              EXT_PIN_BONDED,
  output logic                   TIMER_IRQ
);

  logic [15:0]       count_reg, count_next;
  logic [2:0]        presc_reg, presc_next;
  logic              ovf_reg, ovf_next;
  logic              arm_reg, arm_next;
  logic [7:0]        low_buf_reg, low_buf_next;
  logic              seq_reg, seq_next;
  logic [7:0]        ctrl1_reg, ctrl1_next;
  logic [7:0]        ctrl2_reg, ctrl2_next;
  logic              aw_have_reg, aw_have_next;
  logic              w_have_reg, w_have_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [7:0]        wdata_reg, wdata_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic              wr_fire, rd_fire, ext_edge, tick, load, pin_lvl;
  logic [2:0]        div_mask;
  logic [7:0]        waddr8, raddr8;
  logic              wr_low, wr_main_low, rd_hi, rd_low, rd_main_low, rd_status;
  tfr_csel_t         csel;

  // Address compare at the package's byte width.
  assign waddr8 = 8'(awaddr_reg);
  assign raddr8 = 8'(S_AXI_ARADDR);

  // Handshakes: one write and one read in flight, no buffering beyond one beat each.
  assign S_AXI_AWREADY = ~aw_have_reg & ~bvalid_reg;
  assign S_AXI_WREADY  = ~w_have_reg & ~bvalid_reg;
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign wr_fire       = aw_have_reg & w_have_reg;
  assign rd_fire       = S_AXI_ARVALID & ~rvalid_reg;

  // Access decode, shared by the counter, flag and sequence logic.
  assign wr_low      = wr_fire & ((waddr8 == TFR_OFS_CNT_LO) | (waddr8 == TFR_OFS_ALT_LO));
  assign wr_main_low = wr_fire & (waddr8 == TFR_OFS_CNT_LO);
  assign rd_hi       = rd_fire & ((raddr8 == TFR_OFS_CNT_HI) | (raddr8 == TFR_OFS_ALT_HI));
  assign rd_low      = rd_fire & ((raddr8 == TFR_OFS_CNT_LO) | (raddr8 == TFR_OFS_ALT_LO));
  assign rd_main_low = rd_fire & (raddr8 == TFR_OFS_CNT_LO);
  assign rd_status   = rd_fire & (raddr8 == TFR_OFS_STATUS);

  // An unbonded pin is held at one so it can never produce an edge.
  assign pin_lvl = EXT_PIN_BONDED ? EXT_CLK_PIN : 1'b1;

  tfr_edge_sync u_sync (
    .CLK_SYS (CLK_SYS),
    .RSTN    (RSTN),
    .PIN     (pin_lvl),
    .RISING  (ctrl2_reg[TFR_BIT_EDGE]),
    .EDGE    (ext_edge)
  );

  // Prescaler divide selection; the external pin wins when both select bits are set.
  always_comb begin
    csel = tfr_csel_t'(ctrl2_reg[TFR_CSEL_LSB +: 2]);
    case (csel)
      TFR_CLK_DIV2: div_mask = TFR_MASK_DIV2;
      TFR_CLK_DIV8: div_mask = TFR_MASK_DIV8;
      default:      div_mask = TFR_MASK_DIV4;
    endcase
  end

  // Halt stops prescaler and counter alike; wait mode has no effect on either.
  always_comb begin
    load       = wr_low;
    presc_next = HALT_MODE ? presc_reg : presc_reg + 3'h1;
    if (csel == TFR_CLK_EXT) begin
      tick = ext_edge & ~HALT_MODE;
    end else begin
      tick = ((presc_reg & div_mask) == div_mask) & ~HALT_MODE;
    end
    if (load) begin
      count_next = TFR_RELOAD;
    end else if (tick) begin
      count_next = count_reg + 16'h0001;
    end else begin
      count_next = count_reg;
    end
  end

  // Overflow flag: set beats a clear landing in the same cycle.
  always_comb begin
    arm_next = arm_reg;
    ovf_next = ovf_reg;
    if (rd_status && ovf_reg) begin
      arm_next = 1'b1;
    end
    if ((rd_main_low || wr_main_low) && arm_reg) begin
      ovf_next = 1'b0;
      arm_next = 1'b0;
    end
    if (tick && !load && (count_reg == TFR_CNT_MAX)) begin
      ovf_next = 1'b1;
    end
  end

  // Interrupt request stays pending in the flag until enable and mask allow it.
  assign TIMER_IRQ = ovf_reg & ctrl1_reg[TFR_BIT_OVF_IE] & ~CPU_IMASK;

  // Bus slave: write capture, register update, read mux and sequence buffer.
  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    ctrl1_next   = ctrl1_reg;
    ctrl2_next   = ctrl2_reg;
    low_buf_next = low_buf_reg;
    seq_next     = seq_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_next = 1'b1;
      awaddr_next  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_next = 1'b1;
      wdata_next  = S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0] : wdata_reg;
    end
    if (wr_fire) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = TFR_RESP_OKAY;
      if (waddr8 == TFR_OFS_CTRL1) begin
        ctrl1_next = wdata_reg;
      end else if (waddr8 == TFR_OFS_CTRL2) begin
        ctrl2_next = wdata_reg;
      end else if ((waddr8 == TFR_OFS_CNT_LO) || (waddr8 == TFR_OFS_ALT_LO)) begin
        bresp_next = TFR_RESP_OKAY;
      end else if ((waddr8 == TFR_OFS_CNT_HI) || (waddr8 == TFR_OFS_ALT_HI) ||
                   (waddr8 == TFR_OFS_STATUS)) begin
        bresp_next = TFR_RESP_OKAY;
      end else begin
        bresp_next = TFR_RESP_SLVERR;
      end
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = TFR_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (rd_hi) begin
        rdata_next[7:0] = count_reg[15:8];
        if (!seq_reg) begin
          low_buf_next = count_reg[7:0];
          seq_next     = 1'b1;
        end
      end else if (rd_low) begin
        rdata_next[7:0] = seq_reg ? low_buf_reg : count_reg[7:0];
        seq_next        = 1'b0;
      end else if (raddr8 == TFR_OFS_STATUS) begin
        rdata_next[TFR_BIT_OVF] = ovf_reg;
      end else if (raddr8 == TFR_OFS_CTRL1) begin
        rdata_next[7:0] = ctrl1_reg;
      end else if (raddr8 == TFR_OFS_CTRL2) begin
        rdata_next[7:0] = ctrl2_reg;
      end else begin
        rresp_next = TFR_RESP_SLVERR;
      end
    end
  end

  // All state registers; reset gives identical state so twin timers stay in step.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      count_reg   <= TFR_RELOAD;
      presc_reg   <= 3'h0;
      ovf_reg     <= 1'b0;
      arm_reg     <= 1'b0;
      low_buf_reg <= 8'h00;
      seq_reg     <= 1'b0;
      ctrl1_reg   <= TFR_CTRL_RST;
      ctrl2_reg   <= TFR_CTRL_RST;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 8'h00;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= TFR_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= TFR_RESP_OKAY;
    end else begin
      count_reg   <= count_next;
      presc_reg   <= presc_next;
      ovf_reg     <= ovf_next;
      arm_reg     <= arm_next;
      low_buf_reg <= low_buf_next;
      seq_reg     <= seq_next;
      ctrl1_reg   <= ctrl1_next;
      ctrl2_reg   <= ctrl2_next;
      aw_have_reg <= aw_have_next;
      w_have_reg  <= w_have_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // Wait mode is sampled nowhere on purpose; the counter ignores it.
  logic wait_unused;
  assign wait_unused = WAIT_MODE;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // Checks on counter, flag, interrupt and read sequence.
  reload_on_write_a: assert property (wr_low |=> count_reg == TFR_RELOAD)
    else $error("Low byte write did not reload the counter.");
  count_step_a: assert property (tick && !load |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("Counter did not advance on a tick.");
  ovf_set_a: assert property (tick && !load && count_reg == TFR_CNT_MAX |=> ovf_reg)
    else $error("Rollover did not set the overflow flag.");
  irq_gate_a: assert property (TIMER_IRQ |-> ovf_reg && ctrl1_reg[TFR_BIT_OVF_IE] && !CPU_IMASK)
    else $error("Interrupt raised without flag, enable or with mask.");
  ovf_clear_a: assert property ($fell(ovf_reg) |-> $past(arm_reg) && $past(rd_main_low || wr_main_low))
    else $error("Overflow flag cleared without the two-step sequence.");
  alt_keep_a: assert property (ovf_reg && !rd_main_low && !wr_main_low |=> ovf_reg)
    else $error("Overflow flag lost without a main low byte access.");
  buf_frozen_a: assert property (seq_reg && !rd_low |=> $stable(low_buf_reg))
    else $error("Buffered low byte changed during a read sequence.");
  halt_hold_a: assert property (HALT_MODE && !load |=> $stable(count_reg))
    else $error("Counter moved while halted.");
  div8_tick_a: assert property (csel == TFR_CLK_DIV8 && tick |-> presc_reg == TFR_MASK_DIV8)
    else $error("Divide-by-eight tick at wrong prescaler phase.");
  // The tick must trace back to a selected pin transition seen two and three clocks earlier.
  ext_tick_a: assert property (csel == TFR_CLK_EXT && tick |->
    $past(pin_lvl, 2) == ctrl2_reg[TFR_BIT_EDGE] &&
    $past(pin_lvl, 3) != ctrl2_reg[TFR_BIT_EDGE])
    else $error("External mode ticked without a matching pin transition.");

  rollover_c: cover property (tick && count_reg == TFR_CNT_MAX);
  sequence_c: cover property (rd_hi ##[1:20] rd_low);
  irq_c:      cover property (TIMER_IRQ ##[1:50] !ovf_reg);

endmodule : tfr_timer

// >>> tb/tfr_timer_test.sv
`timescale 1ns/1ps
module tfr_timer_test
  import tfr_pkg::*;
;
  // Design inputs driven here and outputs watched.
  logic        CLK_SYS, RSTN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_RREADY, CPU_IMASK, WAIT_MODE, HALT_MODE;
  logic        EXT_CLK_PIN, EXT_PIN_BONDED, S_AXI_AWREADY, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TIMER_IRQ;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d, live;
  int          fails, n_tests, i;
  tfr_csel_t   cs [3] = '{TFR_CLK_DIV2, TFR_CLK_DIV4, TFR_CLK_DIV8};
  int          dv [3] = '{2, 4, 8};

  tfr_timer #(.ADDR_W(8)) tfr_timer_inst (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .CPU_IMASK(CPU_IMASK), .WAIT_MODE(WAIT_MODE),
    .HALT_MODE(HALT_MODE), .EXT_CLK_PIN(EXT_CLK_PIN), .EXT_PIN_BONDED(EXT_PIN_BONDED),
    .TIMER_IRQ(TIMER_IRQ)
  );

  // Free-running 250 MHz system clock.
  initial CLK_SYS = 1'b0;
  always #2 CLK_SYS = ~CLK_SYS;

  task automatic run(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Ready is sampled mid-cycle, where it has settled, so the edge decision is race free.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ad, wd, ra, rw, b;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge CLK_SYS);
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= v;
    S_AXI_WSTRB   <= 4'hF;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge CLK_SYS);
      ra = S_AXI_AWREADY && !ad;
      rw = S_AXI_WREADY && !wd;
      @(posedge CLK_SYS);
      if (ra) begin
        ad = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (rw) begin
        wd = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do begin
      @(negedge CLK_SYS);
      b = S_AXI_BVALID;
      r = S_AXI_BRESP;
      @(posedge CLK_SYS);
    end while (!b);
    S_AXI_BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ra, rv;
    @(posedge CLK_SYS);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do begin
      @(negedge CLK_SYS);
      ra = S_AXI_ARREADY;
      @(posedge CLK_SYS);
    end while (!ra);
    S_AXI_ARVALID <= 1'b0;
    do begin
      @(negedge CLK_SYS);
      rv = S_AXI_RVALID;
      d  = S_AXI_RDATA;
      r  = S_AXI_RRESP;
      @(posedge CLK_SYS);
    end while (!rv);
    S_AXI_RREADY <= 1'b0;
  endtask : rd

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, e, d);
  endtask : rdc

  // Whole pulses spaced eight clocks, well inside the slowest legal pin rate; the last is left high.
  task automatic pulses(input int k);
    for (int j = 0; j < k; j++) begin
      EXT_CLK_PIN <= 1'b1;
      run(8);
      if (j < k - 1) EXT_CLK_PIN <= 1'b0;
      run(8);
    end
  endtask : pulses

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Watchdog sized well above the several hundred cycles the sequence needs.
  initial begin
    run(20000);
    fails++;
    report_and_stop();
  end

  // Main sequence; halt is used to freeze the count so reads are exact.
  initial begin
    {RSTN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = '0;
    {S_AXI_RREADY, CPU_IMASK, WAIT_MODE, EXT_CLK_PIN} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB, S_AXI_WDATA} = '0;
    HALT_MODE = 1'b1;
    EXT_PIN_BONDED = 1'b1;
    run(4);
    RSTN <= 1'b1;
    rdc("ctrl1 reset", TFR_OFS_CTRL1, 32'h0);
    rdc("ctrl2 reset", TFR_OFS_CTRL2, 32'h0);
    rdc("high reset", TFR_OFS_CNT_HI, 32'hFF);
    rdc("low reset", TFR_OFS_CNT_LO, 32'hFC);
    HALT_MODE <= 1'b0;
    run(40);
    HALT_MODE <= 1'b1;
    wr(TFR_OFS_ALT_LO, 32'h5A);
    chk("reload resp", TFR_RESP_OKAY, r);
    rdc("reload high", TFR_OFS_CNT_HI, 32'hFF);
    HALT_MODE <= 1'b0;
    run(40);
    rd(TFR_OFS_CNT_HI);
    HALT_MODE <= 1'b1;
    rdc("buffered low", TFR_OFS_CNT_LO, 32'hFC);
    rd(TFR_OFS_CNT_LO);
    live = d;
    chk("live low moved", 32'h1, {31'h0, live !== 32'hFC});
    rdc("alt low", TFR_OFS_ALT_LO, live);
    rdc("flag set", TFR_OFS_STATUS, 32'h80);
    chk("irq disabled", 32'h0, {31'h0, TIMER_IRQ});
    wr(TFR_OFS_CTRL1, 32'h80);
    run(2);
    chk("irq on", 32'h1, {31'h0, TIMER_IRQ});
    CPU_IMASK <= 1'b1;
    run(2);
    chk("irq masked", 32'h0, {31'h0, TIMER_IRQ});
    // Alternate low read and write while armed must both leave the flag alone.
    rd(TFR_OFS_ALT_LO);
    wr(TFR_OFS_ALT_LO, 32'h0);
    rdc("flag kept", TFR_OFS_STATUS, 32'h80);
    rd(TFR_OFS_CNT_LO);
    rdc("flag clear", TFR_OFS_STATUS, 32'h0);
    CPU_IMASK <= 1'b0;
    run(2);
    chk("irq off", 32'h0, {31'h0, TIMER_IRQ});
    // Sixty-four clocks span whole prescaler periods, so the tick count is exact at any phase.
    WAIT_MODE <= 1'b1;
    for (i = 0; i < 3; i++) begin
      wr(TFR_OFS_CTRL2, 32'(cs[i]));
      wr(TFR_OFS_CNT_LO, 32'h0);
      HALT_MODE <= 1'b0;
      run(64);
      HALT_MODE <= 1'b1;
      rdc("divided count", TFR_OFS_CNT_LO, 32'(8'(TFR_RELOAD[7:0] + 64 / dv[i])));
    end
    WAIT_MODE <= 1'b0;
    HALT_MODE <= 1'b0;
    wr(TFR_OFS_CTRL2, 32'h3);
    run(8);
    wr(TFR_OFS_CNT_LO, 32'h0);
    pulses(5);
    run(8);
    rdc("ext falling", TFR_OFS_CNT_LO, 32'h00);
    wr(TFR_OFS_CTRL2, 32'h7);
    EXT_CLK_PIN <= 1'b0;
    run(8);
    wr(TFR_OFS_CNT_LO, 32'h0);
    pulses(5);
    run(8);
    rdc("ext rising", TFR_OFS_CNT_LO, 32'h01);
    EXT_PIN_BONDED <= 1'b0;
    wr(TFR_OFS_CTRL2, 32'h3);
    run(8);
    wr(TFR_OFS_CNT_LO, 32'h0);
    pulses(3);
    rdc("unbonded pin", TFR_OFS_CNT_LO, 32'hFC);
    wr(8'h1C, 32'h0);
    chk("unmapped bresp", TFR_RESP_SLVERR, r);
    rd(8'h1C);
    chk("unmapped rresp", TFR_RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0, d);
    // A second reset in mid-count must restart from the reload value.
    wr(TFR_OFS_CTRL2, 32'h1);
    run(30);
    RSTN <= 1'b0;
    HALT_MODE <= 1'b1;
    run(2);
    RSTN <= 1'b1;
    rdc("rerun high", TFR_OFS_CNT_HI, 32'hFF);
    rdc("rerun low", TFR_OFS_CNT_LO, 32'hFC);
    report_and_stop();
  end
endmodule : tfr_timer_test
